/* File: rtl/cpcf_chk.v */
// cpcf_chk: block-check accumulator, crc6 or longitudinal parity per character
// assumes clr and upd come from the framer on character boundaries
`include "cpcf_regs.vh"
module cpcf_chk #(
   parameter       W    = 6,
   parameter [5:0] POLY = `CPCF_CRC6_POLY
) (
   input  wire         clk,
   input  wire         sys_rst,
   input  wire         clr,
   input  wire         upd,
   input  wire         lrc,
   input  wire [W-1:0] ch,
   output wire [W-1:0] chk
);
   reg [W-1:0] chk_q;
   reg [W-1:0] chk_d;

   function [W-1:0] crc_step;
      input [W-1:0] c;
      input [W-1:0] d;
      integer       i;
      reg   [W-1:0] t;
      begin
         t = c;
         for (i = W - 1; i >= 0; i = i - 1) begin
            if (t[W-1] ^ d[i]) begin
               t = {t[W-2:0], 1'b0} ^ POLY[W-1:0];
            end else begin
               t = {t[W-2:0], 1'b0};
            end
         end
         crc_step = t;
      end
   endfunction

   always @* begin
      chk_d = clr ? {W{1'b0}} : chk_q;
      if (upd) begin
         chk_d = lrc ? (chk_d ^ ch) : crc_step(chk_d, ch);
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chk_q <= {W{1'b0}};
      end else begin
         chk_q <= chk_d;
      end
   end
   assign chk = chk_q;
endmodule // cpcf_chk

/* File: rtl/cpcf_framer.v */
// cpcf_framer: receive framer for a synchronous character protocol line
// assumes line_clk and line_data are synchronous to clk, slower than clk/2
`include "cpcf_regs.vh"
module cpcf_framer #(
   parameter W = 6
) (
   input  wire         clk,
   input  wire         sys_rst,
   input  wire [3:0]   avs_address,
   input  wire         avs_read,
   input  wire         avs_write,
   input  wire [31:0]  avs_writedata,
   output reg  [31:0]  avs_readdata,
   output wire         avs_waitrequest,
   input  wire         line_clk,
   input  wire         line_data,
   output reg  [W-1:0] char_data_q,
   output reg          char_valid_q,
   output reg          msg_start_q,
   output reg          in_sync_q,
   output reg          idle_level_q,
   output wire         modified_block_check,
   output wire         irq
);
   localparam S_HUNT = 3'h0;
   localparam S_IDLE = 3'h1;
   localparam S_BCC  = 3'h2;
   localparam S_ACC  = 3'h3;
   localparam S_CRC  = 3'h4;

   reg  [31:0]             ctrl_q;
   reg  [31:0]             sync_q;
   reg  [31:0]             start_q;
   reg  [31:0]             stop_q;
   reg  [31:0]             bcc_q;
   reg  [`CPCF_IRQ_W-1:0]  irq_st_q;
   reg  [`CPCF_IRQ_W-1:0]  irq_mask_q;
   reg  [`CPCF_IRQ_W-1:0]  ev;
   reg                     ack_q;
   reg                     lclk_q;
   reg  [W-1:0]            sh_q;
   reg  [W-1:0]            sh_d;
   reg  [2:0]              bitcnt_q;
   reg  [2:0]              state_q;
   reg  [2:0]              state_d;
   reg  [7:0]              drop_q;
   reg                     bcc_seen_q;
   reg  [W-1:0]            rx_chk_q;
   reg                     chk_clr;
   reg                     chk_upd;
   wire [W-1:0]            chk;
   wire                    line_bit;
   wire                    bit_stb;
   wire                    char_done;
   wire                    resv_code;
   wire                    start_hit;
   wire                    stop_hit;
   wire                    bcc_hit;
   wire                    req;
   wire                    wr_go;

   // bus slave: one wait cycle, answer at the second edge
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_go           = avs_write & ack_q;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~ack_q) begin
         case (avs_address)
            `CPCF_REG_CTRL:     avs_readdata <= ctrl_q;
            `CPCF_REG_SYNC:     avs_readdata <= sync_q;
            `CPCF_REG_START:    avs_readdata <= start_q;
            `CPCF_REG_STOP:     avs_readdata <= stop_q;
            `CPCF_REG_BCC:      avs_readdata <= bcc_q;
            `CPCF_REG_STATUS:   avs_readdata <= {25'h0, modified_block_check, idle_level_q,
                                                 in_sync_q, 1'b0, state_q};
            `CPCF_REG_IRQ_ST:   avs_readdata <= {{(32-`CPCF_IRQ_W){1'b0}}, irq_st_q};
            `CPCF_REG_IRQ_MASK: avs_readdata <= {{(32-`CPCF_IRQ_W){1'b0}}, irq_mask_q};
            `CPCF_REG_RXCHAR:   avs_readdata <= {{(32-W){1'b0}}, char_data_q};
            `CPCF_REG_CHECK:    avs_readdata <= {{(24-W){1'b0}}, rx_chk_q, 2'h0, chk};
            default:            avs_readdata <= 32'h00000000;
         endcase
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q     <= `CPCF_CTRL_RST;
         sync_q     <= `CPCF_SYNC_RST;
         start_q    <= `CPCF_START_RST;
         stop_q     <= `CPCF_STOP_RST;
         bcc_q      <= `CPCF_BCC_RST;
         irq_mask_q <= {`CPCF_IRQ_W{1'b0}};
      end else if (wr_go) begin
         case (avs_address)
            `CPCF_REG_CTRL:     ctrl_q     <= avs_writedata;
            `CPCF_REG_SYNC:     sync_q     <= avs_writedata;
            `CPCF_REG_START:    start_q    <= avs_writedata;
            `CPCF_REG_STOP:     stop_q     <= avs_writedata;
            `CPCF_REG_BCC:      bcc_q      <= avs_writedata;
            `CPCF_REG_IRQ_MASK: irq_mask_q <= avs_writedata[`CPCF_IRQ_W-1:0];
            default:            irq_mask_q <= irq_mask_q;
         endcase
      end
   end

   // sticky events; a new event wins over a write-one clear in the same cycle
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_st_q <= {`CPCF_IRQ_W{1'b0}};
      end else if (wr_go && avs_address == `CPCF_REG_IRQ_ST) begin
         irq_st_q <= (irq_st_q & ~avs_writedata[`CPCF_IRQ_W-1:0]) | ev;
      end else begin
         irq_st_q <= irq_st_q | ev;
      end
   end
   assign irq = |(irq_st_q & irq_mask_q);

   // code selection and line sense
   assign resv_code = (ctrl_q[`CPCF_CTRL_CODE] == `CPCF_CODE_IDLE0) ||
                      (ctrl_q[`CPCF_CTRL_CODE] == `CPCF_CODE_IDLE1);
   // invoked by software, but only honoured off the reservation codes and with equal characters
   assign modified_block_check = ~resv_code & ctrl_q[`CPCF_CTRL_MEC] &
                                 (bcc_q[`CPCF_SLOT0] == bcc_q[`CPCF_SLOT1]);

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_level_q <= 1'b0;
      end else begin
         idle_level_q <= ctrl_q[`CPCF_CTRL_IDLE] ^ ctrl_q[`CPCF_CTRL_INV];
      end
   end

   // the line clock is only sampled; data is taken on its rising edge
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lclk_q <= 1'b0;
      end else begin
         lclk_q <= line_clk;
      end
   end
   assign bit_stb  = line_clk & ~lclk_q & ctrl_q[`CPCF_CTRL_EN];
   assign line_bit = line_data ^ ctrl_q[`CPCF_CTRL_INV];

   always @* begin
      if (ctrl_q[`CPCF_CTRL_MSB]) begin
         sh_d = {sh_q[W-2:0], line_bit};
      end else begin
         sh_d = {line_bit, sh_q[W-1:1]};
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_q     <= {W{1'b0}};
         bitcnt_q <= 3'h0;
      end else if (bit_stb) begin
         sh_q <= sh_d;
         if (state_q == S_HUNT || bitcnt_q == W - 1) begin
            bitcnt_q <= 3'h0;
         end else begin
            bitcnt_q <= bitcnt_q + 3'h1;
         end
      end
   end
   assign char_done = bit_stb && state_q != S_HUNT && bitcnt_q == W - 1;

   cpcf_match #(.N(2), .W(W)) u_start (
      .set_chars ({start_q[`CPCF_SLOT1], start_q[`CPCF_SLOT0]}),
      .ch        (sh_d),
      .hit       (start_hit),
      .hits      ()
   );
   cpcf_match #(.N(4), .W(W)) u_stop (
      .set_chars ({stop_q[`CPCF_SLOT3], stop_q[`CPCF_SLOT2], stop_q[`CPCF_SLOT1], stop_q[`CPCF_SLOT0]}),
      .ch        (sh_d),
      .hit       (stop_hit),
      .hits      ()
   );
   cpcf_match #(.N(2), .W(W)) u_bcc (
      .set_chars ({bcc_q[`CPCF_SLOT1], bcc_q[`CPCF_SLOT0]}),
      .ch        (sh_d),
      .hit       (bcc_hit),
      .hits      ()
   );
   cpcf_chk #(.W(W)) u_chk (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clr     (chk_clr),
      .upd     (chk_upd),
      .lrc     (ctrl_q[`CPCF_CTRL_LRC]),
      .ch      (sh_d),
      .chk     (chk)
   );

   always @* begin
      state_d = state_q;
      chk_clr = 1'b0;
      chk_upd = 1'b0;
      ev      = {`CPCF_IRQ_W{1'b0}};
      if (state_q == S_HUNT) begin
         // the first sync closes the hunt and is dropped, not captured
         if (bit_stb && sh_d == sync_q[`CPCF_SLOT0]) begin
            state_d              = S_IDLE;
            ev[`CPCF_EV_FOUND]   = 1'b1;
         end
      end else if (char_done) begin
         if (sh_d == sync_q[`CPCF_SLOT2] && sync_q[`CPCF_DROP_CNT] != 8'h00 &&
             drop_q + 8'h01 >= sync_q[`CPCF_DROP_CNT]) begin
            state_d             = S_HUNT;
            ev[`CPCF_EV_LOST]   = 1'b1;
         end else begin
            case (state_q)
               S_IDLE: begin
                  // start slots hold the second sync; either one alone opens a message
                  if (start_hit) begin
                     ev[`CPCF_EV_START] = 1'b1;
                     chk_clr            = 1'b1;
                     state_d            = resv_code ? S_ACC : S_BCC;
                  end
               end
               S_BCC: begin
                  if (bcc_hit && !modified_block_check) begin
                     chk_clr = 1'b1;
                     state_d = S_ACC;
                  end else if (!bcc_hit && bcc_seen_q) begin
                     // first character after the run of start-of-check characters
                     chk_clr = 1'b1;
                     chk_upd = 1'b1;
                     state_d = S_ACC;
                  end
               end
               S_ACC: begin
                  chk_upd = 1'b1;
                  if (stop_hit) begin
                     state_d = S_CRC;
                  end
               end
               S_CRC: begin
                  if (sh_d == chk) begin
                     ev[`CPCF_EV_OK]  = 1'b1;
                  end else begin
                     ev[`CPCF_EV_ERR] = 1'b1;
                  end
                  state_d = S_IDLE;
               end
               default: state_d = S_HUNT;
            endcase
         end
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q      <= S_HUNT;
         drop_q       <= 8'h00;
         bcc_seen_q   <= 1'b0;
         rx_chk_q     <= {W{1'b0}};
         char_data_q  <= {W{1'b0}};
         char_valid_q <= 1'b0;
         msg_start_q  <= 1'b0;
         in_sync_q    <= 1'b0;
      end else begin
         state_q      <= ctrl_q[`CPCF_CTRL_EN] ? state_d : S_HUNT;
         in_sync_q    <= (state_d != S_HUNT);
         msg_start_q  <= ev[`CPCF_EV_START];
         // only characters seen while in sync reach the capture stream
         char_valid_q <= char_done;
         if (char_done) begin
            char_data_q <= sh_d;
            drop_q      <= (sh_d == sync_q[`CPCF_SLOT2]) ? drop_q + 8'h01 : 8'h00;
            if (state_q == S_CRC) begin
               rx_chk_q <= sh_d;
            end
         end
         if (state_d == S_HUNT) begin
            drop_q <= 8'h00;
         end
         if (state_q == S_BCC && char_done) begin
            bcc_seen_q <= bcc_hit & modified_block_check;
         end else if (state_q != S_BCC) begin
            bcc_seen_q <= 1'b0;
         end
      end
   end
endmodule // cpcf_framer

/* File: rtl/cpcf_match.v */
// cpcf_match: compares one character against a set of configured characters
// assumes the set arrives packed, slot k in bits k*W .. k*W+W-1
module cpcf_match #(
   parameter N = 4,
   parameter W = 6
) (
   input  wire [N*W-1:0] set_chars,
   input  wire [W-1:0]   ch,
   output wire           hit,
   output wire [N-1:0]   hits
);
   genvar k;
   generate
      for (k = 0; k < N; k = k + 1) begin : g_slot
         // each slot matches on its own; no ordering between them
         assign hits[k] = (set_chars[k*W +: W] == ch);
      end
   endgenerate
   assign hit = |hits;
endmodule // cpcf_match

/* File: rtl/cpcf_regs.vh */
// constants of the character-protocol receive framer: register map, fields, resets
// assumes a word-addressed bus slave and 6-bit line characters by default
// Behaviour
// - reservation codes disable modified block check; others enable it when MEC is set and characters equal
// - first sync character is never captured
// - message start triggers on second sync only
// - idle level is code digit, flipped when inverted
// - drop-sync run of idle characters resumes hunting
// - two separate start characters, not a sequence
// - any of four end characters ends message
// - modified check copes with repeated start-of-check characters
// - modified check only non-reservation and equal characters
// - modified check starts after last start-of-check char
// - normal check starts after first start-of-check char
`ifndef CPCF_REGS_VH
`define CPCF_REGS_VH

// word indices on the register bus
`define CPCF_ADDR_W        4
`define CPCF_REG_CTRL      4'h0
`define CPCF_REG_SYNC      4'h1
`define CPCF_REG_START     4'h2
`define CPCF_REG_STOP      4'h3
`define CPCF_REG_BCC       4'h4
`define CPCF_REG_STATUS    4'h5
`define CPCF_REG_IRQ_ST    4'h6
`define CPCF_REG_IRQ_MASK  4'h7
`define CPCF_REG_RXCHAR    4'h8
`define CPCF_REG_CHECK     4'h9

// control fields
`define CPCF_CTRL_CODE     1:0
`define CPCF_CTRL_IDLE     0
`define CPCF_CTRL_INV      2
`define CPCF_CTRL_MSB      3
`define CPCF_CTRL_LRC      4
`define CPCF_CTRL_MEC      5
`define CPCF_CTRL_EN       6
`define CPCF_CODE_IDLE0    2'h0
`define CPCF_CODE_IDLE1    2'h1

// character slots inside a 32-bit register
`define CPCF_SLOT0         5:0
`define CPCF_SLOT1         13:8
`define CPCF_SLOT2         21:16
`define CPCF_SLOT3         29:24
`define CPCF_DROP_CNT      31:24

// interrupt events
`define CPCF_IRQ_W         5
`define CPCF_EV_START      0
`define CPCF_EV_OK         1
`define CPCF_EV_ERR        2
`define CPCF_EV_LOST       3
`define CPCF_EV_FOUND      4

// reset values
`define CPCF_CTRL_RST      32'h0000006C
`define CPCF_SYNC_RST      32'h043F3E3F
`define CPCF_START_RST     32'h00003E3E
`define CPCF_STOP_RST      32'h3D2D1D0D
`define CPCF_BCC_RST       32'h00000202
`define CPCF_CRC6_POLY     6'h03

`endif

/* File: tb/cpcf_framer_props.sv */
// cpcf_framer_props: concurrent checks on the framer's ports
// assumes one clock domain and default start, sync and stop characters
module cpcf_framer_props #(
   parameter W = 6
) (
   input wire         clk,
   input wire         sys_rst,
   input wire [3:0]   avs_address,
   input wire         avs_read,
   input wire         avs_write,
   input wire [31:0]  avs_writedata,
   input wire [31:0]  avs_readdata,
   input wire         avs_waitrequest,
   input wire         line_clk,
   input wire         line_data,
   input wire [W-1:0] char_data_q,
   input wire         char_valid_q,
   input wire         msg_start_q,
   input wire         in_sync_q,
   input wire         idle_level_q,
   input wire         modified_block_check,
   input wire         irq
);
   timeunit 1ns;
   timeprecision 1ps;
   wire req;
   wire wr_done;
   assign req     = avs_read | avs_write;
   assign wr_done = avs_write & ~avs_waitrequest;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   wait_ack_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
   wait_first_a: assert property ($rose(req) |-> avs_waitrequest) else $error("bus answered at once");
   rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read)) else $error("read data moved");
   pulse_one_a: assert property (char_valid_q |=> !char_valid_q) else $error("char pulse too long");
   start_char_a: assert property (msg_start_q |-> char_valid_q && char_data_q == 6'h3E)
      else $error("start not on second sync");
   start_sync_a: assert property (msg_start_q |-> $past(in_sync_q)) else $error("start before sync");
   hunt_quiet_a: assert property (char_valid_q |-> in_sync_q || $past(in_sync_q))
      else $error("char while hunting");
   mec_change_a: assert property ($changed(modified_block_check) |-> $past(wr_done))
      else $error("check mode moved alone");
   idle_change_a: assert property ($changed(idle_level_q) |-> $past(wr_done) || $past(wr_done, 2)
      || $past(sys_rst, 2)) else $error("idle level moved alone");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2)) else $error("irq fell alone");

   cover property (msg_start_q);
   cover property ($rose(irq));
   cover property ($fell(in_sync_q));
   cover property (modified_block_check);
endmodule // cpcf_framer_props

bind cpcf_framer cpcf_framer_props #(.W(W)) props_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .line_clk(line_clk), .line_data(line_data), .char_data_q(char_data_q),
   .char_valid_q(char_valid_q), .msg_start_q(msg_start_q), .in_sync_q(in_sync_q), .idle_level_q(idle_level_q),
   .modified_block_check(modified_block_check), .irq(irq));

/* File: tb/cpcf_line_tx.sv */
// cpcf_line_tx: far station that clocks characters onto the monitored line
// assumes the bench calls send from its own process, one character at a time
module cpcf_line_tx (
   input  wire  clk,
   output logic line_clk,
   output logic line_data
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      line_clk  = 1'b0;
      line_data = 1'b0;
   end

   // three clk low and two high per bit; the line clock stands still between frames
   task automatic send(input logic [5:0] c);
      for (int i = 5; i >= 0; i--) begin
         @(posedge clk) line_data <= c[i];
         @(posedge clk);
         @(posedge clk) line_clk <= 1'b1;
         @(posedge clk);
         @(posedge clk) line_clk <= 1'b0;
      end
      // a stale bit must not pass for a valid one after the frame
      line_data <= ~c[0];
   endtask
endmodule // cpcf_line_tx

/* File: tb/testbench.sv */
// testbench: drives the framer's register bus and line, judges each scenario
// assumes the framer's register map header and a line station model beside it
`include "cpcf_regs.vh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sys_rst, avs_read, avs_write;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, rd;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, line_clk, line_data, char_valid_q, msg_start_q, in_sync_q, idle_level_q, mbc, irq;
   wire  [5:0]  char_data_q;
   int          n_mismatch = 0, n_checks = 0, n_chars = 0, n_start = 0;
   logic [5:0]  first_ch;

   cpcf_framer #(.W(6)) dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .line_clk(line_clk), .line_data(line_data), .char_data_q(char_data_q),
      .char_valid_q(char_valid_q), .msg_start_q(msg_start_q), .in_sync_q(in_sync_q),
      .idle_level_q(idle_level_q), .modified_block_check(mbc), .irq(irq));
   cpcf_line_tx tx_u (.clk(clk), .line_clk(line_clk), .line_data(line_data));

   initial begin
      clk           = 1'b0;
      sys_rst       = 1'b1;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_address   = 4'h0;
      avs_writedata = 32'h00000000;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (char_valid_q === 1'b1) begin
         if (n_chars == 0)
            first_ch <= char_data_q;
         n_chars <= n_chars + 1;
         n_start <= n_start + (msg_start_q === 1'b1);
      end
   end

   function automatic logic [5:0] crc6(input logic [5:0] c, input logic [5:0] d);
      logic fb;
      for (int i = 5; i >= 0; i--) begin
         fb = c[5] ^ d[i];
         c  = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
      end
      return c;
   endfunction

   // longitudinal check is a plain xor of the characters
   function automatic logic [5:0] acc(input logic l, input logic [5:0] c, input logic [5:0] d);
      return l ? (c ^ d) : crc6(c, d);
   endfunction

   // the station puts on the line what the framer must rebuild under its sense and order settings
   task automatic put(input logic [31:0] ctl, input logic [5:0] c);
      logic [5:0] b;
      logic [5:0] r;
      b = ctl[2] ? ~c : c;
      for (int i = 0; i < 6; i++)
         r[i] = b[5 - i];
      tx_u.send(ctl[3] ? b : r);
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic rdn, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_read      <= rdn;
      avs_write     <= !rdn;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk);
      end
      `CHK("waitrequest", 1'b0, avs_waitrequest)
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0);
      `CHK(nm, e, rd)
   endtask

   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
   endtask

   // full frame; skip says how many start-of-check characters stay out of the check
   task automatic msg(input logic [31:0] ctl, input logic [31:0] mask, input logic [5:0] stop, input logic bad,
                      input int nbcc, input int skip);
      logic [5:0] crc = 6'h00;
      logic [5:0] dat [3] = '{6'h15, 6'h2A, 6'h07};
      do_reset();
      wr(`CPCF_REG_CTRL, ctl);
      wr(`CPCF_REG_IRQ_MASK, mask);
      n_chars = 0;
      n_start = 0;
      put(ctl, 6'h3F);
      put(ctl, 6'h3E);
      for (int i = 0; i < nbcc; i++) begin
         put(ctl, 6'h02);
         crc = (i >= skip) ? acc(ctl[4], crc, 6'h02) : crc;
      end
      foreach (dat[i]) begin
         put(ctl, dat[i]);
         crc = acc(ctl[4], crc, dat[i]);
      end
      put(ctl, stop);
      crc = acc(ctl[4], crc, stop);
      put(ctl, bad ? ~crc : crc);
      repeat (8) @(posedge clk);
      bus(1'b1, `CPCF_REG_IRQ_ST, 32'h0);
      `CHK("check result", bad ? 32'h4 : 32'h2, rd & 32'h6)
      `CHK("chars", nbcc + 6, n_chars)
      bus(1'b1, `CPCF_REG_CHECK, 32'h0);
      `CHK("check regs", ({18'h0, (bad ? ~crc : crc), 2'h0, crc}), rd)
      bus(1'b1, `CPCF_REG_STATUS, 32'h0);
      `CHK("status", ({25'h0, ctl[1] & ctl[5], ctl[0] ^ ctl[2], 1'b1, 1'b0, 3'h1}), rd)
      `CHK("irq raised", mask != 0, irq)
      wr(`CPCF_REG_IRQ_ST, 32'h1F);
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
   endtask

   task automatic t_reset;
      rdchk("ctrl", `CPCF_REG_CTRL, `CPCF_CTRL_RST);
      rdchk("sync", `CPCF_REG_SYNC, `CPCF_SYNC_RST);
      rdchk("start", `CPCF_REG_START, `CPCF_START_RST);
      rdchk("stop", `CPCF_REG_STOP, `CPCF_STOP_RST);
      rdchk("bcc", `CPCF_REG_BCC, `CPCF_BCC_RST);
      wr(4'hF, 32'hFFFFFFFF);
      rdchk("unmapped", 4'hF, 32'h0);
      wr(`CPCF_REG_RXCHAR, 32'h3F);
      rdchk("read only", `CPCF_REG_RXCHAR, 32'h0);
      `CHK("idle level", 1'b1, idle_level_q)
      `CHK("mec", 1'b0, mbc)
      $display("test reset done");
   endtask

   task automatic t_modes;
      for (int m = 0; m < 8; m++) begin
         wr(`CPCF_REG_CTRL, 32'h68 | ((m & 4) == 4 ? 32'h4 : 32'h0) | (m & 3));
         repeat (3) @(posedge clk);
         `CHK("idle level", logic'(m[0] ^ m[2]), idle_level_q)
         `CHK("mec", logic'(m[1]), mbc)
      end
      wr(`CPCF_REG_CTRL, 32'h6A);
      wr(`CPCF_REG_BCC, 32'h0302);
      repeat (2) @(posedge clk);
      `CHK("mec unequal", 1'b0, mbc)
      $display("test modes done");
   endtask

   task automatic t_frames;
      for (int k = 0; k < 4; k++)
         msg(32'h48, 32'h1F, {k[1:0], 4'hD}, k == 3, 0, 0);
      `CHK("first char", 6'h3E, first_ch)
      `CHK("starts", 1, n_start)
      msg(32'h48, 32'h0, 6'h0D, 1'b1, 0, 0);
      msg(32'h6A, 32'h1F, 6'h0D, 1'b0, 3, 3);
      msg(32'h4A, 32'h1F, 6'h1D, 1'b0, 2, 1);
      msg(32'h5A, 32'h1F, 6'h2D, 1'b0, 1, 1);
      msg(32'h44, 32'h1F, 6'h3D, 1'b1, 0, 0);
      $display("test frames done");
   endtask

   task automatic t_drop;
      do_reset();
      wr(`CPCF_REG_CTRL, 32'h48);
      tx_u.send(6'h3F);
      tx_u.send(6'h3E);
      `CHK("in sync", 1'b1, in_sync_q)
      repeat (4) tx_u.send(6'h3F);
      repeat (8) @(posedge clk);
      `CHK("sync dropped", 1'b0, in_sync_q)
      bus(1'b1, `CPCF_REG_IRQ_ST, 32'h0);
      `CHK("lost event", 32'h8, rd & 32'h8)
      $display("test drop done");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // a stuck handshake or line must not hang the run
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      do_reset();
      t_reset();
      t_modes();
      t_frames();
      t_drop();
      tally_and_finish();
   end
endmodule // testbench
